// ---- src/oisp_pkg.sv ----
/*
  Package for the opto-isolated serial port: frame layout, bit-mode codes,
  carrier structs and fifo sizing.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package oisp_pkg;
  // ----------------------------------------------------------------
  // frame layout
  // ----------------------------------------------------------------
  localparam int unsigned OISP_DATA_BITS = 8;
  localparam int unsigned OISP_FRAME_BITS = 10;
  localparam logic [3:0] OISP_LAST_DATA_IDX = 4'h8;
  localparam logic [3:0] OISP_CHAN_BIT_IDX = 4'h9;
  localparam logic OISP_START_BIT = 1'b0;
  localparam logic OISP_IDLE_LEVEL = 1'b1;
  localparam logic OISP_CHAN_FIRST = 1'b0;
  localparam logic OISP_CHAN_SECOND = 1'b1;
  // ----------------------------------------------------------------
  // bit-mode codes
  // ----------------------------------------------------------------
  localparam logic [7:0] OISP_MODE_RELEASE = 8'h00;
  localparam logic [7:0] OISP_MODE_HOLD = 8'h10;
  // ----------------------------------------------------------------
  // buffering
  // ----------------------------------------------------------------
  localparam int unsigned OISP_FIFO_DEPTH = 32;
  localparam int unsigned OISP_WORD_W = 9;
  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic chan;
    logic [7:0] data;
  } oisp_word_t;
  typedef struct packed {
    logic first_en;
    logic second_en;
  } oisp_cfg_t;
endpackage : oisp_pkg

// ---- src/oisp_port.sv ----
/*
  Opto-isolated serial port: fifo plus port top.
  Assumes link_shift_clock, serial_in_line come from outside the sys_clk
  domain, and the bit-mode byte is a level held by the command logic.
*/
`timescale 1ns/1ns
module oisp_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 32
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic do_wr;
  logic do_rd;

  assign in_ready = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;
  assign out_data = mem[rd_ptr_reg];

  always_ff @(posedge sys_clk) begin
    if (do_wr) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (do_wr && !do_rd) begin
        count_reg <= count_reg + 1'b1;
      end else if (do_rd && !do_wr) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule : oisp_fifo

// Summary of operation
// - any channel in serial mode routes the port onto the second channel's pins
// - serial mode per channel comes from configuration memory bits, not commands
// - bit-mode code 10 holds the port reset and silences the output line
// - while held, bytes from usb are still queued but not sent
// - bit-mode code 0 releases the port and queued bytes go out
// - an outgoing frame begins with a low start bit
// - no outgoing frame starts while a frame is being received
// - outgoing data bits go least significant first
// - outgoing frame ends with source channel bit, 0 first, 1 second
// - clear_to_receive drops at the rising clock edge after a start bit
// - eight incoming data bits are captured least significant first
// - destination 0 goes to first channel if enabled, else second
// - destination 1 goes to second channel if enabled, else first
// - with neither channel enabled the link logic is held reset and new usb bytes are dropped; both fifos keep their contents
// - clear_to_receive stays low until another byte can be accepted
module oisp_port #(
  parameter int unsigned DEPTH = oisp_pkg::OISP_FIFO_DEPTH
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // configuration memory bits and bit-mode setting
  input wire oisp_pkg::oisp_cfg_t cfg,
  input wire logic [7:0] bit_mode,
  // usb side, outgoing bytes
  input wire logic tx_valid,
  output logic tx_ready,
  input wire oisp_pkg::oisp_word_t tx_word,
  // usb side, incoming bytes
  output logic rx_valid,
  input wire logic rx_ready,
  output oisp_pkg::oisp_word_t rx_word,
  // pin group select
  output logic second_pins_serial,
  // link pins
  input wire logic link_shift_clock,
  input wire logic serial_in_line,
  output logic serial_out_line,
  output logic clear_to_receive
);
  import oisp_pkg::*;

  // ----------------------------------------------------------------
  // enables and hold
  // ----------------------------------------------------------------
  logic port_on;
  logic hold_reg;
  assign port_on = cfg.first_en || cfg.second_en;
  assign second_pins_serial = port_on;

  // hold is sticky between codes so other bit-mode values leave it alone
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      hold_reg <= 1'b0;
    end else if (bit_mode == OISP_MODE_HOLD) begin
      hold_reg <= 1'b1;
    end else if (bit_mode == OISP_MODE_RELEASE) begin
      hold_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] clk_sync_reg;
  logic [2:0] din_sync_reg;
  logic clk_level_reg;
  logic din_level_reg;
  logic clk_rise;
  logic clk_fall;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      // start at the parked clock level, so release shows no false edge
      clk_sync_reg <= 3'h7;
      din_sync_reg <= 3'h7;
      clk_level_reg <= 1'b1;
      din_level_reg <= 1'b1;
    end else begin
      clk_sync_reg <= {clk_sync_reg[1:0], link_shift_clock};
      din_sync_reg <= {din_sync_reg[1:0], serial_in_line};
      if (clk_sync_reg[2] == clk_sync_reg[1]) begin
        clk_level_reg <= clk_sync_reg[2];
      end
      if (din_sync_reg[2] == din_sync_reg[1]) begin
        din_level_reg <= din_sync_reg[2];
      end
    end
  end

  // edges seen only where stages two and three agree
  // external clock
  assign clk_rise = (clk_sync_reg[2] == clk_sync_reg[1]) && clk_sync_reg[2] && !clk_level_reg;
  assign clk_fall = (clk_sync_reg[2] == clk_sync_reg[1]) && !clk_sync_reg[2] && clk_level_reg;

  // ----------------------------------------------------------------
  // buffers
  // ----------------------------------------------------------------
  oisp_word_t txq_word;
  logic txq_valid;
  logic txq_take;
  oisp_word_t rxq_word_reg;
  logic rxq_push_reg;
  logic rxq_ready;

  oisp_fifo #(.WIDTH(OISP_WORD_W), .DEPTH(DEPTH)) tx_fifo (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .in_valid(tx_valid && port_on),
    .in_ready(tx_ready),
    .in_data(tx_word),
    .out_valid(txq_valid),
    .out_ready(txq_take),
    .out_data(txq_word)
  );

  oisp_fifo #(.WIDTH(OISP_WORD_W), .DEPTH(DEPTH)) rx_fifo (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .in_valid(rxq_push_reg),
    .in_ready(rxq_ready),
    .in_data(rxq_word_reg),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data(rx_word)
  );

  // ----------------------------------------------------------------
  // receiver
  // ----------------------------------------------------------------
  logic rx_busy_reg;
  logic [3:0] rx_idx_reg;
  logic [7:0] rx_shift_reg;
  logic cts_reg;

  always_ff @(posedge sys_clk) begin
    if (!rst_n || !port_on || hold_reg) begin
      rx_busy_reg <= 1'b0;
      rx_idx_reg <= 4'h0;
      rx_shift_reg <= 8'h00;
      rxq_push_reg <= 1'b0;
      rxq_word_reg <= '0;
    end else begin
      rxq_push_reg <= 1'b0;
      if (clk_rise) begin
        if (!rx_busy_reg) begin
          if (din_level_reg == OISP_START_BIT && cts_reg) begin
            rx_busy_reg <= 1'b1;
            rx_idx_reg <= 4'h1;
          end
        end else if (rx_idx_reg == OISP_CHAN_BIT_IDX) begin
          rx_busy_reg <= 1'b0;
          rxq_push_reg <= 1'b1;
          rxq_word_reg.data <= rx_shift_reg;
          if (din_level_reg == OISP_CHAN_FIRST) begin
            rxq_word_reg.chan <= cfg.first_en ? OISP_CHAN_FIRST : OISP_CHAN_SECOND;
          end else begin
            rxq_word_reg.chan <= cfg.second_en ? OISP_CHAN_SECOND : OISP_CHAN_FIRST;
          end
        end else begin
          rx_shift_reg <= {din_level_reg, rx_shift_reg[7:1]};
          rx_idx_reg <= rx_idx_reg + 4'h1;
        end
      end
    end
  end

  // lowered at the rise after a start bit, raised once space remains
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !port_on || hold_reg) begin
      cts_reg <= 1'b0;
    end else if (clk_rise && !rx_busy_reg && din_level_reg == OISP_START_BIT && cts_reg) begin
      cts_reg <= 1'b0;
    end else if (!rx_busy_reg && !rxq_push_reg && rxq_ready) begin
      cts_reg <= 1'b1;
    end
  end
  assign clear_to_receive = cts_reg;

  // ----------------------------------------------------------------
  // transmitter
  // ----------------------------------------------------------------
  logic tx_busy_reg;
  logic [3:0] tx_idx_reg;
  oisp_word_t tx_hold_reg;
  logic out_reg;

  // popped as the start bit goes out so the word stays in hold
  // not while receiving
  assign txq_take = clk_fall && !tx_busy_reg && txq_valid && !rx_busy_reg
                    && !hold_reg && port_on;

  // bits change on the falling edge so the far side samples on the rise
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !port_on || hold_reg) begin
      tx_busy_reg <= 1'b0;
      tx_idx_reg <= 4'h0;
      tx_hold_reg <= '0;
      out_reg <= OISP_IDLE_LEVEL;
    end else if (clk_fall) begin
      if (txq_take) begin
        tx_busy_reg <= 1'b1;
        tx_idx_reg <= 4'h1;
        tx_hold_reg <= txq_word;
        out_reg <= OISP_START_BIT;
      end else if (tx_busy_reg) begin
        if (tx_idx_reg == OISP_CHAN_BIT_IDX) begin
          out_reg <= tx_hold_reg.chan;
          tx_idx_reg <= tx_idx_reg + 4'h1;
        end else if (tx_idx_reg > OISP_CHAN_BIT_IDX) begin
          tx_busy_reg <= 1'b0;
          out_reg <= OISP_IDLE_LEVEL;
        end else begin
          out_reg <= tx_hold_reg.data[3'(tx_idx_reg - 4'h1)];
          tx_idx_reg <= tx_idx_reg + 4'h1;
        end
      end
    end
  end
  // far side may pause the clock; state simply waits for edges
  assign serial_out_line = out_reg;
endmodule : oisp_port

// ---- tb/oisp_chk.sv ----
/* checker bound to oisp_port.
   assumes the far side runs its clock at 80 ns. */
`timescale 1ns/1ns
module oisp_chk
  import oisp_pkg::*;
#(
  parameter int unsigned DEPTH = 32
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // usb side
  input wire oisp_pkg::oisp_cfg_t cfg,
  input wire logic [7:0] bit_mode,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire oisp_pkg::oisp_word_t tx_word,
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire oisp_pkg::oisp_word_t rx_word,
  // link
  input wire logic second_pins_serial,
  input wire logic link_shift_clock,
  input wire logic serial_in_line,
  input wire logic serial_out_line,
  input wire logic clear_to_receive
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ------
  // age of last link fall
  // ------
  logic link_q_reg;
  logic [3:0] age_reg;
  always_ff @(posedge sys_clk) link_q_reg <= link_shift_clock;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) age_reg <= 4'hf;
    else if (link_q_reg && !link_shift_clock) age_reg <= 4'h0;
    else if (age_reg != 4'hf) age_reg <= age_reg + 4'h1;
  end
  // ------
  // properties
  // ------
  AST_PINS: assert property (second_pins_serial == (cfg.first_en | cfg.second_en))
    else $error("pin select wrong");
  AST_HOLD: assert property ((bit_mode == OISP_MODE_HOLD) [*3] |-> serial_out_line)
    else $error("line active while held");
  AST_OFF: assert property ((cfg == 2'b00) [*3] |-> serial_out_line && !clear_to_receive)
    else $error("port active while disabled");
  AST_CTS_DROP: assert property ($rose(link_shift_clock) && !serial_in_line &&
    clear_to_receive |-> ##[2:7] !clear_to_receive) else $error("clear not dropped");
  AST_CTS_STAY: assert property ($fell(clear_to_receive) |=> !clear_to_receive [*8])
    else $error("clear rose too soon");
  AST_OUT_STEP: assert property ($fell(serial_out_line) |-> age_reg <= 4'h6)
    else $error("output moved off link fall");
  AST_RX_PUSH: assert property ($rose(link_shift_clock) && !serial_in_line &&
    clear_to_receive |-> ##[70:90] rx_valid) else $error("received word missing");
  // outputs settle while reset is held
  AST_RST: assert property (disable iff (1'b0) !rst_n ##1 !rst_n |->
    serial_out_line && !clear_to_receive && !rx_valid && tx_ready) else $error("reset state");
  COV_OUT: cover property ($fell(serial_out_line));
  COV_RX: cover property (rx_valid && rx_ready);
  COV_HOLD: cover property (bit_mode == OISP_MODE_HOLD && tx_valid);
endmodule : oisp_chk
bind oisp_port oisp_chk #(.DEPTH(DEPTH)) i_chk (.sys_clk, .rst_n, .cfg, .bit_mode, .tx_valid,
  .tx_ready, .tx_word, .rx_valid, .rx_ready, .rx_word, .second_pins_serial,
  .link_shift_clock, .serial_in_line, .serial_out_line, .clear_to_receive);

// ---- tb/oisp_far.sv ----
/* far device model: makes the link clock, sends and takes frames.
   assumes callers enter its tasks just after a sys_clk edge. */
`timescale 1ns/1ns
module oisp_far (
  // clock
  input wire logic sys_clk,
  // link
  output logic link_shift_clock,
  output logic serial_in_line,
  input wire logic serial_out_line,
  input wire logic clear_to_receive
);
  // pulled-up line, clock parked high outside frames
  initial begin
    link_shift_clock = 1'b1;
    serial_in_line = 1'b1;
  end
  task automatic half(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : half
  // one bit per 80 ns period
  task automatic period(input logic d);
    link_shift_clock <= 1'b0;
    serial_in_line <= d;
    half(4);
    link_shift_clock <= 1'b1;
    half(4);
  endtask : period
  task automatic send(input logic [8:0] w);
    int i;
    for (i = 0; i < 40 && clear_to_receive !== 1'b1; i++) half(1);
    period(1'b0);
    for (i = 0; i < 9; i++) period(w[i]);
    serial_in_line <= 1'b1;
  endtask : send
  // sample late in each period, before the next fall moves it
  task automatic recv(output logic [10:0] b, input int stall);
    int i;
    for (i = 0; i < 11; i++) begin
      period(1'b1);
      if (i == 0) half(stall);
      b[i] = serial_out_line;
    end
  endtask : recv
endmodule : oisp_far

// ---- tb/tb.sv ----
/* bench for oisp_port: usb side by hand, link by oisp_far.
   assumes the checker is bound in by oisp_chk.sv. */
`timescale 1ns/1ns
module tb;
  import oisp_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  oisp_cfg_t cfg = 2'b11;
  logic [7:0] bit_mode = 8'h00;
  logic tx_valid = 1'b0;
  oisp_word_t tx_word = 9'h000;
  logic rx_ready = 1'b0;
  logic tx_ready, rx_valid, second_pins_serial;
  oisp_word_t rx_word;
  logic link_shift_clock, serial_in_line, serial_out_line, clear_to_receive;
  int n_fail = 0;
  int total_checks = 0;
  int cyc = 0;
  logic [10:0] got;
  always #5 sys_clk = ~sys_clk;
  oisp_port i_dut (.sys_clk, .rst_n, .cfg, .bit_mode, .tx_valid, .tx_ready, .tx_word,
    .rx_valid, .rx_ready, .rx_word, .second_pins_serial, .link_shift_clock,
    .serial_in_line, .serial_out_line, .clear_to_receive);
  oisp_far i_far (.sys_clk, .link_shift_clock, .serial_in_line, .serial_out_line,
    .clear_to_receive);
  task automatic report_and_stop;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop
  // a stuck link must not hang the run
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_fail++;
      report_and_stop;
    end
  end
  task automatic chk(input string what, input logic [10:0] exp, input logic [10:0] seen);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic push(input logic [8:0] w);
    tx_valid <= 1'b1;
    tx_word <= w;
    @(posedge sys_clk);
    tx_valid <= 1'b0;
    @(posedge sys_clk);
  endtask : push
  // idle, channel, data lsb first, start
  function automatic logic [10:0] fr(input logic [8:0] w);
    return {1'b1, w, 1'b0};
  endfunction : fr
  task automatic t_out;
    push(9'h1a5);
    push(9'h03c);
    chk("tx ready", 11'h001, {10'h000, tx_ready});
    chk("pin select on", 11'h001, {10'h000, second_pins_serial});
    i_far.recv(got, 20);
    chk("frame ch1", fr(9'h1a5), got);
    i_far.recv(got, 0);
    chk("frame ch0", fr(9'h03c), got);
  endtask : t_out
  task automatic t_hold;
    bit_mode <= OISP_MODE_HOLD;
    repeat (3) @(posedge sys_clk);
    bit_mode <= 8'h02;
    push(9'h15a);
    i_far.recv(got, 0);
    chk("held line", 11'h7ff, got);
    bit_mode <= OISP_MODE_RELEASE;
    repeat (3) @(posedge sys_clk);
    i_far.recv(got, 0);
    chk("released frame", fr(9'h15a), got);
  endtask : t_hold
  task automatic t_in;
    logic [7:0] d;
    logic ec;
    for (int k = 1; k < 4; k++) begin
      for (int i = 0; i < 2; i++) begin
        cfg <= oisp_cfg_t'(k[1:0]);
        d = 8'h5c ^ 8'(k * 2 + i);
        ec = i[0] ? k[0] : ~k[1];
        repeat (3) @(posedge sys_clk);
        i_far.send({i[0], d});
        for (int n = 0; n < 20 && rx_valid !== 1'b1; n++) @(posedge sys_clk);
        chk("rx valid", 11'h001, {10'h000, rx_valid});
        chk("routed word", {2'b00, ec, d}, {2'b00, rx_word});
        rx_ready <= 1'b1;
        @(posedge sys_clk);
        rx_ready <= 1'b0;
        @(posedge sys_clk);
        chk("rx drained", 11'h000, {10'h000, rx_valid});
      end
    end
  endtask : t_in
  task automatic t_dis;
    cfg <= 2'b00;
    repeat (3) @(posedge sys_clk);
    chk("pin select", 11'h000, {10'h000, second_pins_serial});
    chk("clear line", 11'h000, {10'h000, clear_to_receive});
    push(9'h0e7);
    i_far.recv(got, 0);
    chk("disabled line", 11'h7ff, got);
    cfg <= 2'b11;
    repeat (3) @(posedge sys_clk);
    i_far.recv(got, 0);
    chk("dropped word", 11'h7ff, got);
  endtask : t_dis
  // two reset cycles; the synchronisers reset to the idle levels
  initial begin
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    t_out;
    t_hold;
    t_in;
    t_dis;
    report_and_stop;
  end
endmodule : tb
